// ---- rtl/pwm_chan_map.svh ----
// reset values, alignment codes and clock period of one pwm channel
// assumes inclusion by the channel's files only
`ifndef PWM_CHAN_MAP_SVH
`define PWM_CHAN_MAP_SVH
`define PWM_PERIOD_RESET 8'h00
`define PWM_DUTY_RESET   8'h00
`define PWM_CNT_RESET    8'h00
`define PWM_ALIGN_LEFT   1'b0
`define PWM_ALIGN_CENTER 1'b1
`define PWM_CLK_PERIOD_NS 50
`endif

// ---- rtl/pwm_chan_pkg.sv ----
// types shared by the pwm channel files
// assumes the map header for numeric constants
package pwm_chan_pkg;
  typedef enum logic [1:0] {
    CLK_A  = 2'b00,
    CLK_B  = 2'b01,
    CLK_SA = 2'b11,
    CLK_SB = 2'b10
  } clk_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UP   = 2'b01,
    ST_DOWN = 2'b11
  } cnt_state_t;
endpackage

// ---- rtl/pwm_dbuf_reg.sv ----
// one double-buffered 8-bit register: software buffer plus active latch
// assumes load pulses come from the channel logic, one clock domain
`timescale 1ns/100ps
`include "pwm_chan_map.svh"
module pwm_dbuf_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         enabled,
  input  wire logic         load,
  output logic      [W-1:0] buf_q,
  output logic      [W-1:0] act_q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_q <= RST_VAL;
    end else if (wr) begin
      buf_q <= wr_data;
    end
  end
  // disabled writes go straight through; enabled ones wait for a load point
  always_ff @(posedge clk) begin
    if (rst) begin
      act_q <= RST_VAL;
    end else if (wr && !enabled) begin
      act_q <= wr_data;
    end else if (load) begin
      act_q <= buf_q;
    end
  end
endmodule

// ---- rtl/pwm_period_duty_channel.sv ----
// period and duty logic of one pwm channel with double-buffered settings
// assumes prescaled clock enables A, B, SA, SB arrive as one-cycle pulses
`timescale 1ns/100ps
`include "pwm_chan_map.svh"
// What this block does
// RL1 - left aligned: output period is channel clock period times period value
// RL2 - center aligned: output period is channel clock period times twice period
// RL3 - one selected source of A, B, SA, SB clocks all counting
// RL4 - duty compared with counter; on equality the output changes state
// RL5 - enabled duty writes buffered, loaded at period end, counter write, disable
// RL6 - software counter write clears counter and loads buffered values
// RL7 - every period uses wholly the old or wholly the new duty
// RL8 - disabled duty write updates buffer and active latch together
// RL9 - duty read returns last software-written value
// RL10 - polarity 1: start high, go low at duty count
// RL11 - polarity 0: start low, go high at duty count
// RL12 - left counts up and wraps at period; center counts up then down
// RL13 - period double buffered, taking effect at period end, counter write or disable
module pwm_period_duty_channel
  import pwm_chan_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  // prescaled clock enables
  input  wire logic                   I_CE_A,
  input  wire logic                   I_CE_B,
  input  wire logic                   I_CE_SA,
  input  wire logic                   I_CE_SB,
  // channel control
  input  wire logic                   I_ENABLE,
  input  wire pwm_chan_pkg::clk_sel_t I_CLK_SEL,
  input  wire logic                   I_CENTER_ALIGN_SELECT,
  input  wire logic                   I_OUTPUT_POLARITY_SELECT,
  // register writes
  input  wire logic                   I_PERIOD_WR,
  input  wire logic [W-1:0]           I_PERIOD_DATA,
  input  wire logic                   I_DUTY_WR,
  input  wire logic [W-1:0]           I_DUTY_DATA,
  input  wire logic                   I_COUNTER_WR,
  // register reads and state
  output logic      [W-1:0]           O_CHANNEL_PERIOD,
  output logic      [W-1:0]           O_CHANNEL_DUTY,
  output logic      [W-1:0]           O_COUNTER,
  output logic                        O_PWM
);
  import pwm_chan_pkg::*;

  logic         tick;
  logic         en_q;
  logic         boundary;
  logic         load;
  logic [W-1:0] per_buf;
  logic [W-1:0] per_act;
  logic [W-1:0] duty_buf;
  logic [W-1:0] duty_act;
  logic [W-1:0] cnt_q;
  cnt_state_t   state_q;
  logic         match;

  always_comb begin
    unique case (I_CLK_SEL)
      CLK_A:  tick = I_CE_A; // RL3
      CLK_B:  tick = I_CE_B;
      CLK_SA: tick = I_CE_SA;
      CLK_SB: tick = I_CE_SB;
    endcase
  end

  // end of the effective period: wrap in left mode, return to zero in center
  assign boundary = tick && I_ENABLE && (I_CENTER_ALIGN_SELECT
                    ? (state_q == ST_DOWN && cnt_q <= W'(1))
                    : (cnt_q + W'(1) >= per_act)); // RL1 RL2
  assign load = boundary || I_COUNTER_WR || (en_q && !I_ENABLE); // RL5 RL6 RL7
  assign match = (cnt_q == duty_act); // RL4

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      en_q <= 1'b0;
    end else begin
      en_q <= I_ENABLE;
    end
  end

  pwm_dbuf_reg #(.W(W), .RST_VAL(W'(`PWM_DUTY_RESET))) u_duty (
    .clk     (I_CLK),
    .rst     (I_RST),
    .wr      (I_DUTY_WR),
    .wr_data (I_DUTY_DATA),
    .enabled (I_ENABLE),
    .load    (load),
    .buf_q   (duty_buf),
    .act_q   (duty_act)
  ); // RL5 RL8

  pwm_dbuf_reg #(.W(W), .RST_VAL(W'(`PWM_PERIOD_RESET))) u_per (
    .clk     (I_CLK),
    .rst     (I_RST),
    .wr      (I_PERIOD_WR),
    .wr_data (I_PERIOD_DATA),
    .enabled (I_ENABLE),
    .load    (load),
    .buf_q   (per_buf),
    .act_q   (per_act)
  ); // RL13

  // counter; a zero period parks it at zero
  always_ff @(posedge I_CLK) begin
    if (I_RST || I_COUNTER_WR || !I_ENABLE) begin
      cnt_q   <= W'(`PWM_CNT_RESET); // RL6
      state_q <= ST_IDLE;
    end else if (tick) begin
      unique case (state_q)
        ST_IDLE, ST_UP: begin
          if (!I_CENTER_ALIGN_SELECT) begin
            cnt_q   <= boundary ? '0 : cnt_q + W'(1); // RL12
            state_q <= ST_UP;
          end else if (cnt_q + W'(1) >= per_act) begin
            cnt_q   <= per_act;
            state_q <= ST_DOWN; // RL12
          end else begin
            cnt_q   <= cnt_q + W'(1);
            state_q <= ST_UP;
          end
        end
        ST_DOWN: begin
          cnt_q   <= (cnt_q == '0) ? '0 : cnt_q - W'(1);
          state_q <= boundary ? ST_UP : ST_DOWN;
        end
        default: begin
          cnt_q   <= '0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // output level; forced to idle level of polarity while disabled
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PWM <= 1'b0;
    end else if (!I_ENABLE || I_COUNTER_WR) begin
      O_PWM <= I_OUTPUT_POLARITY_SELECT; // RL10 RL11
    end else if (match) begin
      // center mode returns to the start level on the way down, so the pulse stays symmetric
      O_PWM <= (I_CENTER_ALIGN_SELECT && state_q == ST_DOWN)
               ? I_OUTPUT_POLARITY_SELECT : !I_OUTPUT_POLARITY_SELECT; // RL4 RL10 RL11
    end else if (cnt_q == '0 && state_q != ST_DOWN) begin
      // restart level one cycle after the wrap, in step with the match lag
      O_PWM <= I_OUTPUT_POLARITY_SELECT;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_CHANNEL_PERIOD <= W'(`PWM_PERIOD_RESET);
      O_CHANNEL_DUTY   <= W'(`PWM_DUTY_RESET);
      O_COUNTER        <= W'(`PWM_CNT_RESET);
    end else begin
      O_CHANNEL_PERIOD <= per_buf;
      O_CHANNEL_DUTY   <= duty_buf; // RL9
      O_COUNTER        <= cnt_q;
    end
  end

  // assertions
  property p_dis_duty;
    @(posedge I_CLK) disable iff (I_RST)
      (I_DUTY_WR && !I_ENABLE) |=> (duty_act == $past(I_DUTY_DATA));
  endproperty
  a_dis_duty: assert property (p_dis_duty) else $error("disabled duty write not direct"); // RL8

  property p_hold_duty;
    @(posedge I_CLK) disable iff (I_RST)
      (!load && !(I_DUTY_WR && !I_ENABLE)) |=> $stable(duty_act);
  endproperty
  a_hold_duty: assert property (p_hold_duty) else $error("active duty changed mid period"); // RL5

  property p_readback;
    @(posedge I_CLK) disable iff (I_RST)
      I_DUTY_WR |=> ##1 (O_CHANNEL_DUTY == $past(I_DUTY_DATA, 2));
  endproperty
  a_readback: assert property (p_readback) else $error("duty readback wrong"); // RL9

  property p_cnt_clear;
    @(posedge I_CLK) disable iff (I_RST)
      I_COUNTER_WR |=> (cnt_q == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear"); // RL6

  property p_per_hold;
    @(posedge I_CLK) disable iff (I_RST)
      (I_ENABLE && en_q && !load) |=> $stable(per_act);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("period changed off boundary"); // RL13

  property p_match;
    @(posedge I_CLK) disable iff (I_RST)
      (I_ENABLE && !I_COUNTER_WR && match)
        |=> (O_PWM == ($past(I_CENTER_ALIGN_SELECT && state_q == ST_DOWN)
                       ? $past(I_OUTPUT_POLARITY_SELECT) : !$past(I_OUTPUT_POLARITY_SELECT)));
  endproperty
  a_match: assert property (p_match) else $error("no output change on match"); // RL4

  property p_left_wrap;
    @(posedge I_CLK) disable iff (I_RST)
      (I_ENABLE && !I_COUNTER_WR && !I_CENTER_ALIGN_SELECT && tick && boundary) |=> (cnt_q == '0);
  endproperty
  a_left_wrap: assert property (p_left_wrap) else $error("left counter did not wrap"); // RL12

  property p_center_bound;
    @(posedge I_CLK) disable iff (I_RST)
      (I_ENABLE && I_CENTER_ALIGN_SELECT && state_q != ST_IDLE) |-> (cnt_q <= per_act || load);
  endproperty
  a_center_bound: assert property (p_center_bound) else $error("center counter beyond period"); // RL2

  property p_disabled_level;
    @(posedge I_CLK) disable iff (I_RST)
      !I_ENABLE |=> (O_PWM == $past(I_OUTPUT_POLARITY_SELECT));
  endproperty
  a_disabled_level: assert property (p_disabled_level) else $error("idle level wrong"); // RL10
endmodule

// ---- bench/pwm_load_model.sv ----
// load-side model: measures period and high time seen on the pwm pin
// assumes the pin is sampled on the channel clock, one domain
`timescale 1ns/100ps
module pwm_load_model (
  // pin side
  input  wire logic clk,
  input  wire logic pin,
  // measurements
  output int        rises,
  output int        period,
  output int        high
);
  int   cnt;
  int   hc;
  logic prev;
  initial begin
    rises = 0;
    cnt = 0;
    hc = 0;
    prev = 1'b0;
  end
  // a load only sees whole cycles, so glitches inside one cycle are invisible
  always @(posedge clk) begin
    prev <= pin;
    if (pin && !prev) begin
      rises <= rises + 1;
      period <= cnt;
      high <= hc;
      cnt <= 1;
      hc <= 1;
    end else begin
      cnt <= cnt + 1;
      hc <= hc + int'(pin);
    end
  end
endmodule

// ---- bench/test_pwm_period_duty_channel.sv ----
// self-checking bench for one pwm channel against a period and duty model
// assumes the selected clock enable ticks every second cycle
`timescale 1ns/100ps
module test_pwm_period_duty_channel;
  import pwm_chan_pkg::*;
  logic       I_CLK = 1'b0;
  logic       I_RST = 1'b1;
  logic       en = 1'b0;
  logic       cas = 1'b0;
  logic       pol = 1'b0;
  logic       pwr = 1'b0;
  logic       dwr = 1'b0;
  logic       cwr = 1'b0;
  logic       ph = 1'b0;
  logic [3:0] ce = 4'h0;
  logic [7:0] dat = 8'h00;
  logic [7:0] o_per;
  logic [7:0] o_duty;
  logic [7:0] o_cnt;
  logic       o_pwm;
  clk_sel_t   sel = CLK_A;
  int         n_errors = 0;
  int         compares = 0;
  int         rises, mper, mhigh, p, d, d2;
  always #25 I_CLK = ~I_CLK;
  // unselected enables stay random so a wrong select shows as a wrong period
  always @(posedge I_CLK) begin
    logic [3:0] t;
    t = 4'($urandom);
    t[(sel == CLK_A) ? 0 : (sel == CLK_B) ? 1 : (sel == CLK_SA) ? 2 : 3] = ph;
    ph <= ~ph;
    ce <= t;
  end
  pwm_period_duty_channel DUT (.I_CLK(I_CLK), .I_RST(I_RST), .I_CE_A(ce[0]), .I_CE_B(ce[1]),
    .I_CE_SA(ce[2]), .I_CE_SB(ce[3]), .I_ENABLE(en), .I_CLK_SEL(sel), .I_CENTER_ALIGN_SELECT(cas),
    .I_OUTPUT_POLARITY_SELECT(pol), .I_PERIOD_WR(pwr), .I_PERIOD_DATA(dat), .I_DUTY_WR(dwr),
    .I_DUTY_DATA(dat), .I_COUNTER_WR(cwr), .O_CHANNEL_PERIOD(o_per), .O_CHANNEL_DUTY(o_duty),
    .O_COUNTER(o_cnt), .O_PWM(o_pwm));
  pwm_load_model load (.clk(I_CLK), .pin(o_pwm), .rises(rises), .period(mper), .high(mhigh));
  task automatic test_done();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge I_CLK);
    dat <= v;
    pwr <= (k == 0);
    dwr <= (k == 1);
    cwr <= (k == 2);
    @(posedge I_CLK);
    pwr <= 1'b0;
    dwr <= 1'b0;
    cwr <= 1'b0;
  endtask
  task automatic meas(input int n);
    int r0;
    r0 = rises;
    for (int i = 0; i < 4000 && rises < r0 + n; i++) @(posedge I_CLK);
    if (rises < r0 + n) begin
      chk(rises, r0 + n);
      test_done();
    end
  endtask
  // model: two cycles per tick, center doubles the period
  function automatic int hi_exp(input int a, input int q, input int pp, input int dd);
    return (q != 0 ? dd : pp - dd) * (a != 0 ? 4 : 2);
  endfunction
  initial begin
    void'($urandom(15882));
    repeat (3) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    #1 chk(o_per, 32'h00);
    chk(o_duty, 32'h00);
    for (int m = 0; m < 16; m++) begin
      p = 4 + $urandom_range(16);
      d = 1 + $urandom_range(p - 2);
      @(posedge I_CLK);
      en <= 1'b0;
      cas <= m[0];
      // last pass ends center with polarity 0: no high pulse straddles a load point
      pol <= ~m[1];
      sel <= clk_sel_t'(m[3:2]);
      wr(0, 8'(p));
      wr(1, 8'(d));
      @(posedge I_CLK);
      #1 chk(o_duty, d);
      chk(o_per, p);
      @(posedge I_CLK);
      en <= 1'b1;
      meas(3);
      chk(mper, p * (cas ? 4 : 2));
      chk(mhigh, hi_exp(cas, pol, p, d));
    end
    d2 = (d == 1) ? p - 1 : 1;
    wr(1, 8'(d2));
    @(posedge I_CLK);
    #1 chk(o_duty, d2);
    meas(1);
    if (mhigh != hi_exp(cas, pol, p, d)) chk(mhigh, hi_exp(cas, pol, p, d2));
    meas(2);
    chk(mhigh, hi_exp(cas, pol, p, d2));
    wr(2, 8'h00);
    @(posedge I_CLK);
    #1 chk(o_cnt, 32'h00);
    test_done();
  end
endmodule
